/* src/gbms_consts.svh */
// Behaviour
// - Each clock rise rotates pattern one stage right
// - Unmerged gate follows clock high while selected
// - Merged gate spans rise to deselecting rise
// - Merged gates of consecutive periods join
// - Trigger only on gate low-to-high transition
// - Trigger lasts trig_len cycles (one for zero), restarting on a new gate rise
// - Pattern held in sixteen-bit shift register
// - Bus requested when any selected stage assigned
// - Bus one gate suppresses bus two
`ifndef GBMS_CONSTS_SVH
`define GBMS_CONSTS_SVH

`define GBMS_STAGES 16
`define GBMS_BUSES 3
`define GBMS_ADDR_W 8

`define GBMS_REG_CTRL 8'h00
`define GBMS_REG_TRIG_LEN 8'h04
`define GBMS_REG_ASSIGN 8'h08
`define GBMS_REG_PATTERN 8'h0C
`define GBMS_REG_STATUS 8'h10

`define GBMS_CTRL_MERGE_LSB 0
`define GBMS_STAT_GATE_LSB 0
`define GBMS_STAT_TRIG_LSB 4
`define GBMS_STAT_CLK_BIT 8

`define GBMS_CLK_PERIOD_NS 10
`define GBMS_TRIG_TIME_NS 5000
`define GBMS_TRIG_CYCLES ((`GBMS_TRIG_TIME_NS + `GBMS_CLK_PERIOD_NS - 1) / `GBMS_CLK_PERIOD_NS)

`define GBMS_RST_PATTERN 16'h0001
`define GBMS_RST_ASSIGN 32'h0000_0000
`define GBMS_RST_MERGE 3'h0

`define GBMS_RESP_OKAY 2'h0
`define GBMS_RESP_SLVERR 2'h2

`endif

/* src/gbms_pkg.sv */
package gbms_pkg;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
	} gbms_sync_t;

	typedef struct packed {
		logic [2:0] prev;
		logic [2:0][15:0] cnt;
		logic [2:0] trig;
	} gbms_trig_t;

	typedef struct packed {
		logic [15:0] pattern;
		logic [2:0] sel;
		logic [2:0] gate;
		logic [2:0] merge;
		logic [15:0] trig_len;
		logic [31:0] assign_map;
		logic aw_got;
		logic [7:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} gbms_top_t;

endpackage

/* src/gbms_sync.sv */
`timescale 1ns/1ps
`include "gbms_consts.svh"
module gbms_sync
	import gbms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic din,
	output logic level,
	output logic rise
);
	gbms_sync_t cur;
	gbms_sync_t nxt;

	always_comb begin
		nxt = cur;
		nxt.s1 = din;
		nxt.s2 = cur.s1;
		nxt.s3 = cur.s2;
		// Level only moves once two stages agree, filtering a one-sample glitch
		if (cur.s2 == cur.s3) begin
			nxt.level = cur.s3;
		end
		nxt.rise = nxt.level & ~cur.level;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign level = cur.level;
	assign rise = cur.rise;
endmodule // gbms_sync

/* src/gbms_trig.sv */
`timescale 1ns/1ps
`include "gbms_consts.svh"
module gbms_trig
	import gbms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] gate,
	input wire logic [15:0] trig_len,
	output logic [2:0] trig
);
	gbms_trig_t cur;
	gbms_trig_t nxt;
	logic [15:0] load;

	always_comb begin
		nxt = cur;
		// A zero length still gives a one-cycle pulse
		load = (trig_len == 16'h0000) ? 16'h0000 : trig_len - 16'h0001;
		for (int b = 0; b < `GBMS_BUSES; b++) begin
			nxt.prev[b] = gate[b];
			if (gate[b] && !cur.prev[b]) begin
				nxt.trig[b] = 1'b1;
				nxt.cnt[b] = load;
			end else if (cur.trig[b]) begin
				if (cur.cnt[b] == 16'h0000) begin
					nxt.trig[b] = 1'b0;
				end else begin
					nxt.cnt[b] = cur.cnt[b] - 16'h0001;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
		end else begin
			cur <= nxt;
		end
	end

	assign trig = cur.trig;
endmodule // gbms_trig

/* src/gbms_top.sv */
`timescale 1ns/1ps
`include "gbms_consts.svh"
module gbms_top
	import gbms_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic seq_clk_in,
	output logic [2:0] gate,
	output logic [2:0] trig,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	gbms_top_t cur;
	gbms_top_t nxt;
	logic clk_level;
	logic clk_rise;
	logic [2:0] trig_q;
	logic [15:0] shifted;
	logic [2:0] req;

	// Bus code 1..3 in a stage's two-bit field routes it to bus 0..2; 0 routes nowhere
	function automatic logic bus_request(input logic [15:0] pat, input logic [31:0] map,
			input logic [1:0] code);
		logic hit;
		hit = 1'b0;
		for (int i = 0; i < `GBMS_STAGES; i++) begin
			if (pat[i] && (map[2*i +: 2] == code)) begin
				hit = 1'b1;
			end
		end
		return hit;
	endfunction

	function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] data,
			input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int k = 0; k < 4; k++) begin
			if (strb[k]) begin
				res[8*k +: 8] = data[8*k +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic reg_mapped(input logic [7:0] addr);
		return (addr == `GBMS_REG_CTRL) || (addr == `GBMS_REG_TRIG_LEN)
			|| (addr == `GBMS_REG_ASSIGN) || (addr == `GBMS_REG_PATTERN)
			|| (addr == `GBMS_REG_STATUS);
	endfunction

	gbms_sync u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.din(seq_clk_in),
		.level(clk_level),
		.rise(clk_rise)
	);

	gbms_trig u_trig (
		.aclk(aclk),
		.aresetn(aresetn),
		.gate(cur.gate),
		.trig_len(cur.trig_len),
		.trig(trig_q)
	);

	always_comb begin
		logic [31:0] wval;
		logic [7:0] waddr;
		logic [7:0] raddr;
		wval = 32'h0000_0000;
		waddr = 8'h00;
		raddr = 8'h00;
		nxt = cur;
		req = 3'h0;

		// Sequencer: rotate right, stage 16 wraps into stage 1
		shifted = {cur.pattern[14:0], cur.pattern[15]};
		if (clk_rise) begin
			nxt.pattern = shifted;
			// Selection is taken from the new pattern and held for the whole period
			for (int b = 0; b < `GBMS_BUSES; b++) begin
				req[b] = bus_request(shifted, cur.assign_map, 2'(b + 1));
			end
			nxt.sel = req;
			if (req[0]) begin
				nxt.sel[1] = 1'b0;
			end
		end

		for (int b = 0; b < `GBMS_BUSES; b++) begin
			if (cur.merge[b]) begin
				// Selection is held between rises, so adjacent periods stay high
				nxt.gate[b] = nxt.sel[b];
			end else begin
				nxt.gate[b] = nxt.sel[b] & clk_level;
			end
		end

		// Write channel: address and data may come in either order
		if (cur.bvalid && s_axi_bready) begin
			nxt.bvalid = 1'b0;
		end
		if (s_axi_awvalid && cur.awready) begin
			nxt.aw_got = 1'b1;
			nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && cur.wready) begin
			nxt.w_got = 1'b1;
			nxt.wdata = s_axi_wdata;
			nxt.wstrb = s_axi_wstrb;
		end
		if (nxt.aw_got && nxt.w_got && !nxt.bvalid) begin
			waddr = {nxt.aw_addr[7:2], 2'b00};
			nxt.aw_got = 1'b0;
			nxt.w_got = 1'b0;
			nxt.bvalid = 1'b1;
			nxt.bresp = reg_mapped(waddr) ? `GBMS_RESP_OKAY : `GBMS_RESP_SLVERR;
			unique case (waddr)
				`GBMS_REG_CTRL: begin
					wval = strobe_merge({29'h0, cur.merge}, nxt.wdata, nxt.wstrb);
					nxt.merge = wval[`GBMS_CTRL_MERGE_LSB +: 3];
				end
				`GBMS_REG_TRIG_LEN: begin
					wval = strobe_merge({16'h0, cur.trig_len}, nxt.wdata, nxt.wstrb);
					nxt.trig_len = wval[15:0];
				end
				`GBMS_REG_ASSIGN: begin
					nxt.assign_map = strobe_merge(cur.assign_map, nxt.wdata, nxt.wstrb);
				end
				`GBMS_REG_PATTERN: begin
					// A software load overrides a shift landing in the same cycle
					wval = strobe_merge({16'h0, cur.pattern}, nxt.wdata, nxt.wstrb);
					nxt.pattern = wval[15:0];
				end
				default: begin
				end
			endcase
		end
		// One write at a time: no new beat until the response is taken
		nxt.awready = !nxt.aw_got && !nxt.bvalid;
		nxt.wready = !nxt.w_got && !nxt.bvalid;

		// Read channel
		if (cur.rvalid && s_axi_rready) begin
			nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && cur.arready) begin
			raddr = {s_axi_araddr[7:2], 2'b00};
			nxt.rvalid = 1'b1;
			nxt.rresp = reg_mapped(raddr) ? `GBMS_RESP_OKAY : `GBMS_RESP_SLVERR;
			nxt.rdata = 32'h0000_0000;
			unique case (raddr)
				`GBMS_REG_CTRL: nxt.rdata = {29'h0, cur.merge};
				`GBMS_REG_TRIG_LEN: nxt.rdata = {16'h0, cur.trig_len};
				`GBMS_REG_ASSIGN: nxt.rdata = cur.assign_map;
				`GBMS_REG_PATTERN: nxt.rdata = {16'h0, cur.pattern};
				`GBMS_REG_STATUS: begin
					nxt.rdata[`GBMS_STAT_GATE_LSB +: 3] = cur.gate;
					nxt.rdata[`GBMS_STAT_TRIG_LSB +: 3] = trig_q;
					nxt.rdata[`GBMS_STAT_CLK_BIT] = clk_level;
				end
				default: begin
				end
			endcase
		end
		nxt.arready = !nxt.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cur <= '0;
			cur.pattern <= `GBMS_RST_PATTERN;
			cur.assign_map <= `GBMS_RST_ASSIGN;
			cur.merge <= `GBMS_RST_MERGE;
			cur.trig_len <= 16'(`GBMS_TRIG_CYCLES);
		end else begin
			cur <= nxt;
		end
	end

	assign gate = cur.gate;
	assign trig = trig_q;
	assign s_axi_awready = cur.awready;
	assign s_axi_wready = cur.wready;
	assign s_axi_bvalid = cur.bvalid;
	assign s_axi_bresp = cur.bresp;
	assign s_axi_arready = cur.arready;
	assign s_axi_rvalid = cur.rvalid;
	assign s_axi_rdata = cur.rdata;
	assign s_axi_rresp = cur.rresp;
endmodule // gbms_top

/* bench/gbms_assertions.sv */
`timescale 1ns/1ps
module gbms_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic seq_clk_in,
	input wire logic [2:0] gate,
	input wire logic [2:0] trig,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bus_one_wins: assert property (!(gate[0] && gate[1]))
		else $error("bus two gated beside bus one");
	a_trig_bus_one: assert property ($rose(gate[0]) |=> trig[0])
		else $error("no trigger after gate rise");
	a_trig_bus_two: assert property ($rose(gate[1]) |=> trig[1])
		else $error("no trigger after gate rise");
	a_trig_cause: assert property ($rose(trig[2]) |-> $past(gate[2]) && !$past(gate[2], 2))
		else $error("trigger without gate rise");
	a_gate_needs_clk: assert property ($rose(gate[1]) |-> $past(seq_clk_in, 4))
		else $error("gate rose without clock");
	// Seven quiet cycles cover the sync chain plus the update edge
	a_gate_still: assert property ((!s_axi_wvalid && $stable(seq_clk_in))[*7] |=> $stable(gate))
		else $error("gate moved without clock rise");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer held");
endmodule // gbms_assertions
bind gbms_top gbms_assertions gbms_assertions_i (.*);

/* bench/gbms_synth_model.sv */
`timescale 1ns/1ps
module gbms_synth_model #(
	parameter int LEN = 4
) (
	input wire logic aclk,
	input wire logic [2:0] gate,
	input wire logic [2:0] trig,
	output logic [2:0][7:0] n_trig,
	output logic [7:0] n_bad
);
	logic [2:0] prev = 3'h0;
	int len [3] = '{0, 0, 0};
	initial n_trig = '0;
	initial n_bad = 8'h00;
	// A voice fires on the trigger edge only, so a held gate must not refire it
	always @(posedge aclk) begin
		for (int b = 0; b < 3; b++) begin
			if (trig[b] && !prev[b]) n_trig[b] = n_trig[b] + 8'h01;
			if (trig[b] && !prev[b] && !gate[b]) n_bad = n_bad + 8'h01;
			if (trig[b]) len[b] = len[b] + 1;
			if (!trig[b] && prev[b] && len[b] != LEN) n_bad = n_bad + 8'h01;
			if (!trig[b]) len[b] = 0;
		end
		prev = trig;
	end
endmodule // gbms_synth_model

/* bench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, seq_clk_in = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0, last = 3'h0, m, gate, trig;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, asg = 32'h0001_AB40;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [2:0][7:0] n_trig;
	logic [7:0] n_bad;
	logic [15:0] p = 16'h0005;
	logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
	logic [31:0] rv [6] = '{32'h0, 32'h1F4, 32'h0, 32'h1, 32'h0, 32'h0};
	logic [2:0] mv [3] = '{3'h0, 3'h7, 3'h2};
	int fail_count = 0, n_compared = 0;
	int ex [3] = '{0, 0, 0};
	always #5 aclk = ~aclk;
	gbms_top gbms_top_i (.*);
	gbms_synth_model #(.LEN(4)) gbms_synth_model_i (.*);
	task automatic close_out();
		$display("compared %0d, mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h, want %h", $time, g, e);
		end
	endtask
	task automatic gone(input int k);
		chk(32'(k < 99), 32'h1);
		if (k >= 99) close_out();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int k;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		for (k = 0; k < 99; k++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		gone(k);
		chk(32'(s_axi_bresp), 32'(r));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		int k;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		for (k = 0; k < 99; k++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		gone(k);
		chk(s_axi_rdata, e);
		chk(32'(s_axi_rresp), 32'(r));
	endtask
	function automatic logic [2:0] sel_of(input logic [15:0] pt);
		logic [2:0] r;
		r = 3'h0;
		for (int i = 0; i < 16; i++) begin
			if (pt[i] && asg[2*i+:2] != 2'h0) r[asg[2*i+:2] - 2'h1] = 1'b1;
		end
		if (r[0]) r[1] = 1'b0;
		return r;
	endfunction
	task automatic pulse(input int hi);
		logic [2:0] s;
		logic [2:0] t;
		p = {p[14:0], p[15]};
		s = sel_of(p);
		t = s & ~last;
		for (int b = 0; b < 3; b++) ex[b] += int'(t[b]);
		seq_clk_in <= 1'b1;
		repeat (7) @(posedge aclk);
		chk(32'(gate), 32'(s));
		// Status is read while the clock is high and a fresh trigger still runs
		rd(8'h10, {23'h0, 1'b1, 1'b0, t, 1'b0, s}, 2'h0);
		repeat (hi - 7) @(posedge aclk);
		seq_clk_in <= 1'b0;
		repeat (10) @(posedge aclk);
		last = s & m;
		chk(32'(gate), 32'(last));
	endtask
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 6; i++) rd(ra[i], rv[i], (i == 5) ? 2'h2 : 2'h0);
		wr(8'h14, 32'hFFFF_FFFF, 2'h2);
		wr(8'h04, 32'h4, 2'h0);
		// Only byte one is enabled, so the set low byte must not land
		s_axi_wstrb <= 4'h2;
		wr(8'h04, 32'hFFFF_00FF, 2'h0);
		s_axi_wstrb <= 4'hF;
		wr(8'h08, asg, 2'h0);
		// Start and wrap points select no assigned stage, so mode writes never move a gate
		wr(8'h0C, 32'(p), 2'h0);
		rd(8'h04, 32'h4, 2'h0);
		foreach (mv[j]) begin
			m = mv[j];
			wr(8'h00, 32'(m), 2'h0);
			for (int i = 0; i < 16; i++) pulse(8 + 6 * (i % 2));
			rd(8'h0C, 32'(p), 2'h0);
		end
		for (int b = 0; b < 3; b++) chk(32'(n_trig[b]), ex[b]);
		chk(32'(n_bad), 32'h0);
		close_out();
	end
endmodule // tb_top
